// ===== pbc_regs.sv
/*
 * pbc_regs: PHY management register bank, basic control register in full.
 * Assumes MAC-side management logic issues one-cycle indexed rd/wr strobes;
 * other mapped registers live elsewhere and are supplied on other_rdata_in.
 */
// Notes on behaviour
// [R1] The bank is reached only by index through the management request port, never by memory address.
// [R2] Indexes 0-6, 16, 17, 18, 26, 27, 29, 30 and 31 are decoded as mapped registers.
// [R3] Fields kept across soft reset hold only across the soft reset, not across chip reset.
// [R4] Writing 1 to bit 15 starts a soft reset and the bit clears itself when done; default 0.
// [R5] The manager writes all other control bits as zero when setting the soft reset bit.
// [R6] After soft reset the PHY is in normal mode with loopback and power down off.
// [R7] Bit 14 selects loopback when 1; reset 0.
// [R8] Bit 13 selects 100 Mbps when 1, reset 1, and is ignored while auto-negotiation is on.
// [R9] Bit 12 enables auto-negotiation, reset 1, and the negotiated result then overrides bits 13 and 8.
// [R10] Bit 11 selects power down when 1; reset 0.
// [R11] The manager clears auto-negotiation enable in an earlier write before setting power down.
// [R12] Writing 1 to bit 9 restarts auto-negotiation; the bit self-clears and reads 0 normally.
// [R13] Bit 8 selects full duplex when 1, reset 0, and applies only with auto-negotiation off.
// [R14] Bit 7 enables the collision test when 1; reset 0.
// [R15] Reserved bits 10 and 6:0 read zero and ignore writes.
// [R16] Unmapped indexes read zero and ignore writes.
`default_nettype none
module pbc_regs
	import pbc_pkg::*;
#(
	parameter int SRST_CYC = PBC_SRST_CYC
) (
	input  wire logic      clk_in,         // 125 MHz management clock
	input  wire logic      rstn_in,        // chip reset, sync, active low
	input  wire pbc_req_t  req_in,         // indexed read/write request
	input  wire logic [15:0] other_rdata_in, // read data of other mapped indexes
	input  wire logic      an_done_in,     // negotiation result valid
	input  wire logic      an_speed100_in, // negotiated 100 Mbps
	input  wire logic      an_full_in,     // negotiated full duplex
	output logic [15:0]    rdata_out,      // read data
	output logic           rvalid_out,     // read data valid pulse
	output pbc_mode_t      mode_out,       // effective operating mode
	output logic           an_restart_out, // restart negotiation pulse
	output logic           soft_rst_out    // soft reset in progress
);
	localparam int CW = $clog2(SRST_CYC + 1);

	typedef struct packed {
		logic        srst;
		logic [CW-1:0] cnt;
		logic        loop;
		logic        speed;
		logic        anen;
		logic        pdown;
		logic        anrst;
		logic        dup;
		logic        col;
		logic [15:0] rdata;
		logic        rvalid;
		pbc_mode_t   mode;
	} pbc_state_t;

	pbc_state_t st_r;
	pbc_state_t st_nxt;
	logic       mapped;
	logic       is_bctl;
	logic [15:0] bctl_view;

	// ==========================================================
	// index decode
	pbc_idx_dec u_dec (
		.idx_in     (req_in.idx),
		.mapped_out (mapped),
		.bctl_out   (is_bctl)
	);

	always_comb begin
		bctl_view = 16'h0000; // R15
		bctl_view[PBC_B_RESET]   = st_r.srst;
		bctl_view[PBC_B_LOOP]    = st_r.loop;
		bctl_view[PBC_B_SPEED]   = st_r.speed;
		bctl_view[PBC_B_ANEN]    = st_r.anen;
		bctl_view[PBC_B_PDOWN]   = st_r.pdown;
		bctl_view[PBC_B_ANRST]   = st_r.anrst; // R12
		bctl_view[PBC_B_DUPLEX]  = st_r.dup;
		bctl_view[PBC_B_COLTEST] = st_r.col;
	end

	// ==========================================================
	// next state
	always_comb begin
		st_nxt        = st_r;
		st_nxt.rvalid = 1'b0;
		st_nxt.anrst  = 1'b0; // R12
		if (req_in.rd) begin // R1
			st_nxt.rvalid = 1'b1;
			if (!mapped)
				st_nxt.rdata = 16'h0000; // R16
			else if (is_bctl)
				st_nxt.rdata = bctl_view;
			else
				st_nxt.rdata = other_rdata_in;
		end
		if (st_r.srst) begin
			// no kept_across_soft_reset fields in this register: all return to defaults
			if (st_r.cnt == CW'(SRST_CYC - 1)) begin
				st_nxt.srst  = 1'b0; // R4
				st_nxt.cnt   = '0;
				st_nxt.loop  = 1'b0; // R6
				st_nxt.pdown = 1'b0; // R6
				st_nxt.speed = PBC_RST_SPEED; // R3
				st_nxt.anen  = PBC_RST_ANEN;
				st_nxt.dup   = 1'b0;
				st_nxt.col   = 1'b0;
			end else begin
				st_nxt.cnt = st_r.cnt + CW'(1);
			end
		end else if (req_in.wr && is_bctl) begin // R16
			// writes during soft reset are dropped; manager zeroes others with reset bit (R5)
			if (req_in.wdata[PBC_B_RESET]) begin
				st_nxt.srst = 1'b1; // R4
				st_nxt.cnt  = '0;
			end else begin
				st_nxt.loop  = req_in.wdata[PBC_B_LOOP];    // R7
				st_nxt.speed = req_in.wdata[PBC_B_SPEED];   // R8
				st_nxt.anen  = req_in.wdata[PBC_B_ANEN];    // R9
				st_nxt.pdown = req_in.wdata[PBC_B_PDOWN];   // R10 R11
				st_nxt.dup   = req_in.wdata[PBC_B_DUPLEX];  // R13
				st_nxt.col   = req_in.wdata[PBC_B_COLTEST]; // R14
				st_nxt.anrst = req_in.wdata[PBC_B_ANRST];   // R12
			end
		end
		// effective mode: negotiated result wins while enabled and valid; last speed and duplex held while enabled and not valid
		st_nxt.mode.loopback = st_nxt.loop;
		st_nxt.mode.pdown    = st_nxt.pdown;
		st_nxt.mode.col_test = st_nxt.col;
		st_nxt.mode.an_en    = st_nxt.anen;
		st_nxt.mode.speed100 = st_nxt.anen ? an_speed100_in : st_nxt.speed; // R8 R9
		st_nxt.mode.full_dup = st_nxt.anen ? an_full_in : st_nxt.dup;       // R9 R13
		if (st_nxt.anen && !an_done_in) begin
			st_nxt.mode.speed100 = st_r.mode.speed100;
			st_nxt.mode.full_dup = st_r.mode.full_dup;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			st_r       <= '0;
			st_r.speed <= PBC_RST_SPEED;
			st_r.anen  <= PBC_RST_ANEN;
			st_r.mode.an_en    <= PBC_RST_ANEN;
			st_r.mode.speed100 <= PBC_RST_SPEED;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_out      = st_r.rdata;
	assign rvalid_out     = st_r.rvalid;
	assign mode_out       = st_r.mode;
	assign an_restart_out = st_r.anrst;
	assign soft_rst_out   = st_r.srst;

	// ==========================================================
	// checks
	sequence s_srst_wr;
		req_in.wr && is_bctl && req_in.wdata[PBC_B_RESET] && !st_r.srst;
	endsequence
	sequence s_srst_done;
		!soft_rst_out && !mode_out.loopback && !mode_out.pdown;
	endsequence

	AST_SRST_DONE: assert property (@(posedge clk_in) disable iff (!rstn_in) // R6
		s_srst_wr |=> soft_rst_out ##[1:300] s_srst_done)
		else $error("soft reset did not finish into normal mode");
	AST_SRST_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in) // R4
		s_srst_wr |=> soft_rst_out[*2])
		else $error("soft reset bit did not hold");
	AST_LOOP_WR: assert property (@(posedge clk_in) disable iff (!rstn_in) // R7
		(req_in.wr && is_bctl && !req_in.wdata[PBC_B_RESET] && !st_r.srst)
		|=> mode_out.loopback == $past(req_in.wdata[PBC_B_LOOP]))
		else $error("loopback bit not taken");
	AST_PDOWN_WR: assert property (@(posedge clk_in) disable iff (!rstn_in) // R10
		(req_in.wr && is_bctl && !req_in.wdata[PBC_B_RESET] && !st_r.srst)
		|=> mode_out.pdown == $past(req_in.wdata[PBC_B_PDOWN]))
		else $error("power down bit not taken");
	AST_ANRST_PULSE: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
		an_restart_out && !(req_in.wr && is_bctl) |=> !an_restart_out)
		else $error("restart bit did not self clear");
	AST_MAN_SPEED: assert property (@(posedge clk_in) disable iff (!rstn_in) // R8
		!mode_out.an_en |-> mode_out.speed100 == st_r.speed)
		else $error("manual speed not applied");
	AST_MAN_DUP: assert property (@(posedge clk_in) disable iff (!rstn_in) // R13
		!mode_out.an_en |-> mode_out.full_dup == st_r.dup)
		else $error("manual duplex not applied");
	AST_UNMAPPED: assert property (@(posedge clk_in) disable iff (!rstn_in) // R16
		(req_in.rd && !mapped) |=> rvalid_out && rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	AST_RSVD: assert property (@(posedge clk_in) disable iff (!rstn_in) // R15
		(req_in.rd && is_bctl) |=> (rdata_out & ~PBC_BCTL_WMASK) == 16'h0000)
		else $error("reserved bits not zero");
	AST_COL_WR: assert property (@(posedge clk_in) disable iff (!rstn_in) // R14
		(req_in.wr && is_bctl && !req_in.wdata[PBC_B_RESET] && !st_r.srst)
		|=> mode_out.col_test == $past(req_in.wdata[PBC_B_COLTEST]))
		else $error("collision test bit not taken");
endmodule : pbc_regs
`default_nettype wire

// ===== pbc_pkg.sv
/*
 * pbc_pkg: constants and carrier types for the PHY basic control register bank.
 * Assumes a single 125 MHz management clock and synchronous active-low reset.
 */
`default_nettype none
package pbc_pkg;
	// ==========================================================
	// register indexes
	localparam logic [4:0] PBC_IDX_BCTL   = 5'h00;
	localparam logic [4:0] PBC_IDX_BSTAT  = 5'h01;
	localparam logic [4:0] PBC_IDX_ID1    = 5'h02;
	localparam logic [4:0] PBC_IDX_ID2    = 5'h03;
	localparam logic [4:0] PBC_IDX_ANADV  = 5'h04;
	localparam logic [4:0] PBC_IDX_ANLPA  = 5'h05;
	localparam logic [4:0] PBC_IDX_ANEXP  = 5'h06;
	localparam logic [4:0] PBC_IDX_EDTIME = 5'h10;
	localparam logic [4:0] PBC_IDX_MODE   = 5'h11;
	localparam logic [4:0] PBC_IDX_SPMODE = 5'h12;
	localparam logic [4:0] PBC_IDX_SYMERR = 5'h1A;
	localparam logic [4:0] PBC_IDX_SPIND  = 5'h1B;
	localparam logic [4:0] PBC_IDX_ISRC   = 5'h1D;
	localparam logic [4:0] PBC_IDX_IMASK  = 5'h1E;
	localparam logic [4:0] PBC_IDX_SPCTL  = 5'h1F;
	// ==========================================================
	// basic control field positions
	localparam int PBC_B_RESET   = 15;
	localparam int PBC_B_LOOP    = 14;
	localparam int PBC_B_SPEED   = 13;
	localparam int PBC_B_ANEN    = 12;
	localparam int PBC_B_PDOWN   = 11;
	localparam int PBC_B_ANRST   = 9;
	localparam int PBC_B_DUPLEX  = 8;
	localparam int PBC_B_COLTEST = 7;
	localparam logic [15:0] PBC_BCTL_WMASK = 16'hFB80;
	// ==========================================================
	// reset values and timing
	localparam logic PBC_RST_SPEED = 1'b1;
	localparam logic PBC_RST_ANEN  = 1'b1;
	localparam int   PBC_SRST_NS   = 400;
	localparam int   PBC_CLK_NS    = 8;
	localparam int   PBC_SRST_CYC  = (PBC_SRST_NS + PBC_CLK_NS - 1) / PBC_CLK_NS;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [4:0] idx;
		logic [15:0] wdata;
	} pbc_req_t;
	typedef struct packed {
		logic loopback;
		logic speed100;
		logic an_en;
		logic pdown;
		logic full_dup;
		logic col_test;
	} pbc_mode_t;
endpackage : pbc_pkg
`default_nettype wire

// ===== pbc_idx_dec.sv
/*
 * pbc_idx_dec: decodes a register index into mapped/control hits.
 * Assumes indexes are stable while the request strobe is high.
 */
`default_nettype none
module pbc_idx_dec
	import pbc_pkg::*;
(
	input  wire logic [4:0] idx_in,    // register index
	output logic            mapped_out, // index is in the map
	output logic            bctl_out    // index selects basic control
);
	// ==========================================================
	// decode
	function automatic logic pbc_is_mapped(input logic [4:0] i);
		unique case (i)
			PBC_IDX_BCTL, PBC_IDX_BSTAT, PBC_IDX_ID1, PBC_IDX_ID2,
			PBC_IDX_ANADV, PBC_IDX_ANLPA, PBC_IDX_ANEXP, PBC_IDX_EDTIME,
			PBC_IDX_MODE, PBC_IDX_SPMODE, PBC_IDX_SYMERR, PBC_IDX_SPIND,
			PBC_IDX_ISRC, PBC_IDX_IMASK, PBC_IDX_SPCTL: pbc_is_mapped = 1'b1; // R2
			default: pbc_is_mapped = 1'b0; // R16
		endcase
	endfunction : pbc_is_mapped

	assign mapped_out = pbc_is_mapped(idx_in);
	assign bctl_out   = (idx_in == PBC_IDX_BCTL);
endmodule : pbc_idx_dec
`default_nettype wire

// ===== pbc_mac_mgmt.sv
/* pbc_mac_mgmt: MAC-side management access model, indexed read/write strobes.
 * Assumes the bank answers a read at the taking edge, so the data is valid 1 ns after it. */
`default_nettype none
module pbc_mac_mgmt
	import pbc_pkg::*;
(
	input  wire logic        clk_in,    // management clock
	input  wire logic [15:0] rdata_in,  // bank read data
	input  wire logic        rvalid_in, // bank read valid
	output var  pbc_req_t    req_out    // indexed request
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req_out = '0;
	// ==========================================================
	// access tasks
	task automatic wr(input logic [4:0] i, input logic [15:0] d);
		@(posedge clk_in);
		req_out.idx   <= i;
		req_out.wdata <= d[15] ? 16'h8000 : d;
		req_out.wr    <= 1'b1;
		@(posedge clk_in);
		req_out.wr    <= 1'b0;
		// released data must not look valid
		req_out.wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [4:0] i, output logic [15:0] q, output logic v);
		@(posedge clk_in);
		req_out.idx <= i;
		req_out.rd  <= 1'b1;
		@(posedge clk_in);
		req_out.rd  <= 1'b0;
		#1;
		q = rdata_in;
		v = rvalid_in;
	endtask : rd
endmodule : pbc_mac_mgmt
`default_nettype wire

// ===== testbench.sv
/* testbench: drives pbc_regs through the management model and compares
 * every control register read and the mode with an integer model of it, other reads with oth or zero.
 * Assumes an_done_in is high except in one hold scenario near the end. */
`default_nettype none
module testbench
	import pbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SR = 4;
	logic        clk_in, rstn_in, an_done, an_spd, an_full, rvalid, an_rst, srst, v;
	logic [15:0] oth, rdata, lf, q, d;
	pbc_req_t    req;
	pbc_mode_t   mode;
	int          error_cnt = 0, n_tests = 0, cyc = 0, m, n;
	pbc_regs #(.SRST_CYC(SR)) DUT (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req),
		.other_rdata_in(oth), .an_done_in(an_done), .an_speed100_in(an_spd), .an_full_in(an_full),
		.rdata_out(rdata), .rvalid_out(rvalid), .mode_out(mode), .an_restart_out(an_rst), .soft_rst_out(srst));
	pbc_mac_mgmt mac (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// whole run is well under a thousand cycles
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	// ==========================================================
	// helpers
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
	endfunction : nxt
	function automatic bit mapped(input int i);
		return i <= 6 || i inside {16, 17, 18, 26, 27, 29, 30, 31};
	endfunction : mapped
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic rd_chk(input int i, input logic [15:0] exp);
		pbc_mode_t e;
		mac.rd(5'(i), q, v);
		chk(16'(v), 16'h0001, "rvalid");
		chk(q, exp, "rdata");
		e = {m[14], m[12] ? an_spd : m[13], m[12], m[11], m[12] ? an_full : m[8], m[7]};
		chk(16'(mode), 16'(e), "mode");
	endtask : rd_chk
	task automatic wr0(input logic [15:0] dd);
		mac.wr(5'h00, dd);
		if (srst !== 1'b1)
			m = dd[15] ? 32'h3000 : 32'(dd & 16'h7980);
		#1;
		chk(16'(an_rst), 16'(dd[9] & ~dd[15] & ~srst), "restart");
	endtask : wr0
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// main sequence
	initial begin
		rstn_in = 1'b0;
		an_done = 1'b1;
		an_spd  = 1'b0;
		an_full = 1'b1;
		oth     = 16'h0000;
		lf      = 16'd79;
		m       = 32'h3000;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd_chk(0, 16'h3000);
		for (int k = 0; k < 60; k++) begin
			lf = nxt(lf);
			d  = lf & 16'h7FFF;
			@(posedge clk_in);
			an_spd  <= lf[3];
			an_full <= lf[5];
			if (d[11])
				wr0(d & 16'hE7FF);
			wr0(d[11] ? d & 16'hEFFF : d);
			rd_chk(0, 16'(m));
		end
		wr0(16'h4180);
		wr0(16'h4A00);
		rd_chk(0, 16'(m));
		// soft reset, with a write landing inside it
		wr0(16'hC900);
		chk(16'(srst), 16'h0001, "soft reset busy");
		wr0(16'h4000);
		n = 0;
		while (srst !== 1'b0 && n < SR + 2) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk(16'(srst), 16'h0000, "soft reset done");
		rd_chk(0, 16'h3000);
		wr0(16'h6180);
		for (int i = 0; i < 32; i++) begin
			lf = nxt(lf);
			@(posedge clk_in);
			oth <= lf;
			if (i != 0)
				mac.wr(5'(i), 16'h4880);
			rd_chk(i, i == 0 ? 16'(m) : (mapped(i) ? lf : 16'h0000));
		end
		rd_chk(0, 16'(m));
		// chip reset in mid-run restores defaults
		@(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		m = 32'h3000;
		rd_chk(0, 16'h3000);
		// result not valid: effective speed and duplex keep the last result
		@(posedge clk_in);
		an_done <= 1'b0;
		d = {14'h0000, an_spd, an_full};
		@(posedge clk_in);
		an_spd  <= ~an_spd;
		an_full <= ~an_full;
		repeat (3) @(posedge clk_in);
		#1;
		chk(16'({mode.speed100, mode.full_dup}), d, "held result");
		an_done <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		chk(16'({mode.speed100, mode.full_dup}), d ^ 16'h0003, "new result");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
